// ===== hdl/flash_ctl.sv
/*
 * host-side controller for an asynchronous NOR flash: sequences unlock and
 * command cycles, reads status bits, polls toggle bit TOGGLE_A and reports ready_busy_n.
 * assumes software behind an AXI4-Lite slave and a flash with no clock.
 */
// Decided for this implementation: register access over AXI4-Lite and the address map.
// Functional notes
// - command cycles are writes; array and autoselect id cycles are reads.
// - reset command is issued on request and after a timeout_flag failure.
// - autoselect id reads are given the bank address from the address register.
// - id reads are plain read ops after autoselect entry; software reads three cycles.
// - bypass program allowed only after bypass enter, until bypass exit or a reset command run as OP_RESET, and not while suspended.
// - resume only offered while suspended, with bank address.
// - after poll completion one more read fetches fully valid data.
// - on timeout_flag the toggle is rechecked before failure is declared.
`default_nettype none
module flash_ctl
    import flash_ctl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output flash_ctl_pkg::pins_t pins,
    input wire logic [15:0] dq_in,
    input wire logic ready_busy_n
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001, S_SETUP = 6'b000010, S_STROBE = 6'b000100,
        S_HOLD = 6'b001000, S_POLL = 6'b010000, S_DONE = 6'b100000
    } state_t;
    state_t state_q;
    step_t seq_q [0:5];
    logic [2:0] nsteps_q, idx_q;
    logic [CNT_W-1:0] cnt_q;
    logic [20:0] addr_q;
    logic [15:0] data_q, rdata_q, dq_s1_q, dq_s2_q, prev_q;
    logic [3:0] op_q;
    logic rb_s1_q, rb_s2_q;
    logic busy_q, done_q, fail_q, bypass_q, erasing_q, suspended_q, go_q, polling_q;
    logic have_prev_q, recheck_q, final_rd_q, aw_q, w_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0] cmd_op;
    logic cmd_ok;
    assign cmd_op = wd_q[3:0];
    // gate commands by mode
    always_comb
    begin
        case (cmd_op)
            OP_BYP_PROG: cmd_ok = bypass_q && !suspended_q;
            OP_SUSPEND: cmd_ok = erasing_q && !suspended_q;
            OP_RESUME: cmd_ok = suspended_q;
            OP_PROG, OP_SECT_ERASE, OP_CHIP_ERASE, OP_BYP_ENTER:
                cmd_ok = !(erasing_q && !suspended_q);
            default: cmd_ok = 1'b1;
        endcase
    end
    // pin synchronisers
    always_ff @(posedge aclk)
    begin
        dq_s1_q <= dq_in;
        dq_s2_q <= dq_s1_q;
        rb_s1_q <= ready_busy_n;
        rb_s2_q <= rb_s1_q;
    end
    // axi write channel capture and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_q <= 1'b0; w_q <= 1'b0; s_bvalid <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0;
            s_awready <= 1'b0; s_wready <= 1'b0;
        end
        else
        begin
            // one-cycle ready pulses, only with no capture or answer pending
            s_awready <= s_awvalid && !s_awready && !aw_q && !s_bvalid;
            s_wready <= s_wvalid && !s_wready && !w_q && !s_bvalid;
            if (s_awvalid && s_awready)
            begin
                aw_q <= 1'b1; awa_q <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                w_q <= 1'b1; wd_q <= s_wdata;
            end
            if (aw_q && w_q)
            begin
                aw_q <= 1'b0; w_q <= 1'b0; s_bvalid <= 1'b1;
            end
            if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
        end
    end
    assign s_bresp = 2'b00;
    // axi read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_rvalid <= 1'b0; s_rdata <= 32'h0; s_arready <= 1'b0;
        end
        else
        begin
            s_arready <= !s_rvalid && !s_arready && s_arvalid;
            if (s_arvalid && s_arready)
            begin
                s_rvalid <= 1'b1;
                case (s_araddr)
                    OFS_ADDR: s_rdata <= {11'h0, addr_q};
                    OFS_DATA: s_rdata <= {16'h0, data_q};
                    OFS_STAT: s_rdata <= {21'h0, rdata_q[TOGGLE_B], rdata_q[TIMER_F],
                        rb_s2_q, suspended_q, erasing_q, bypass_q, 2'b00,
                        fail_q, done_q, busy_q};
                    OFS_RDATA: s_rdata <= {16'h0, rdata_q};
                    default: s_rdata <= 32'h0;
                endcase
            end
            else if (s_rvalid && s_rready)
                s_rvalid <= 1'b0;
        end
    end
    assign s_rresp = 2'b00;
    // register writes and sequence build
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            addr_q <= 21'h0; data_q <= 16'h0; op_q <= 4'h0; nsteps_q <= 3'd0; go_q <= 1'b0;
            for (int i = 0; i < 6; i++)
                seq_q[i] <= '0;
        end
        else
        begin
            go_q <= 1'b0;
            if (aw_q && w_q && !busy_q)
            begin
                case (awa_q)
                    OFS_ADDR: addr_q <= wd_q[20:0];
                    OFS_DATA: data_q <= wd_q[15:0];
                    OFS_CMD:
                    if (cmd_ok)
                    begin
                        go_q <= 1'b1;
                        op_q <= cmd_op;
                        // two unlock pairs, sector bits zero, upper byte zero
                        seq_q[0] <= '{{5'h0, UNLOCK_A1}, {8'h0, UNLOCK_D1}, 1'b0};
                        seq_q[1] <= '{{5'h0, UNLOCK_A2}, {8'h0, UNLOCK_D2}, 1'b0};
                        seq_q[3] <= '{{5'h0, UNLOCK_A1}, {8'h0, UNLOCK_D1}, 1'b0};
                        seq_q[4] <= '{{5'h0, UNLOCK_A2}, {8'h0, UNLOCK_D2}, 1'b0};
                        case (cmd_op)
                            OP_READ:
                            begin
                                seq_q[0] <= '{addr_q, 16'h0, 1'b1}; nsteps_q <= 3'd1;
                            end
                            OP_PROG:
                            begin
                                seq_q[2] <= '{{5'h0, UNLOCK_A1}, {8'h0, FC_PROG}, 1'b0};
                                seq_q[3] <= '{addr_q, data_q, 1'b0}; nsteps_q <= 3'd4;
                            end
                            OP_SECT_ERASE, OP_CHIP_ERASE:
                            begin
                                seq_q[2] <= '{{5'h0, UNLOCK_A1}, {8'h0, FC_ERASE}, 1'b0};
                                seq_q[5] <= (cmd_op == OP_CHIP_ERASE) ?
                                    '{{5'h0, UNLOCK_A1}, {8'h0, FC_CHIP}, 1'b0} :
                                    '{addr_q, {8'h0, FC_SECT}, 1'b0};
                                nsteps_q <= 3'd6;
                            end
                            OP_SUSPEND:
                            begin
                                seq_q[0] <= '{addr_q, {8'h0, FC_SUSP}, 1'b0}; nsteps_q <= 3'd1;
                            end
                            OP_RESUME:
                            begin
                                seq_q[0] <= '{addr_q, {8'h0, FC_RESUME}, 1'b0};
                                nsteps_q <= 3'd1;
                            end
                            OP_AUTOSEL, OP_BYP_ENTER:
                            begin
                                seq_q[2] <= '{{5'h0, UNLOCK_A1},
                                    {8'h0, (cmd_op == OP_AUTOSEL) ? FC_AUTOSEL : FC_BYPASS}, 1'b0};
                                nsteps_q <= 3'd3;
                            end
                            OP_BYP_PROG:
                            begin
                                seq_q[0] <= '{addr_q, {8'h0, FC_PROG}, 1'b0};
                                seq_q[1] <= '{addr_q, data_q, 1'b0}; nsteps_q <= 3'd2;
                            end
                            OP_BYP_EXIT:
                            begin
                                seq_q[0] <= '{addr_q, {8'h0, FC_AUTOSEL}, 1'b0};
                                seq_q[1] <= '{addr_q, {8'h0, FC_BYP_RST2}, 1'b0}; nsteps_q <= 3'd2;
                            end
                            OP_RAW_WRITE:
                            begin
                                seq_q[0] <= '{addr_q, data_q, 1'b0}; nsteps_q <= 3'd1;
                            end
                            default:
                            begin
                                seq_q[0] <= '{21'h0, {8'h0, FC_RESET}, 1'b0}; nsteps_q <= 3'd1;
                            end
                        endcase
                    end
                    default: ;
                endcase
            end
            else if (state_q == S_POLL && !final_rd_q && recheck_q && have_prev_q &&
                     rdata_q[TOGGLE_A] != prev_q[TOGGLE_A] && rdata_q[TIMEOUT_F])
            begin
                // same decision as the poll state: the sequence becomes one reset write
                seq_q[0] <= '{21'h0, {8'h0, FC_RESET}, 1'b0};
                nsteps_q <= 3'd1;
                op_q <= OP_RESET;
            end
        end
    end
    // bus cycle sequencer with status polling
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= S_IDLE; idx_q <= 3'd0; cnt_q <= '0; busy_q <= 1'b0; done_q <= 1'b0;
            fail_q <= 1'b0; bypass_q <= 1'b0; erasing_q <= 1'b0; suspended_q <= 1'b0;
            rdata_q <= 16'h0; prev_q <= 16'h0; polling_q <= 1'b0; have_prev_q <= 1'b0;
            recheck_q <= 1'b0; final_rd_q <= 1'b0;
            pins <= '{21'h0, 1'b1, 1'b1, 1'b1, 16'h0, 1'b0};
        end
        else
        begin
            case (state_q)
                S_IDLE:
                if (go_q)
                begin
                    busy_q <= 1'b1; done_q <= 1'b0; fail_q <= 1'b0; idx_q <= 3'd0;
                    polling_q <= 1'b0; have_prev_q <= 1'b0; recheck_q <= 1'b0;
                    final_rd_q <= 1'b0; cnt_q <= CNT_W'(SETUP_CYC); state_q <= S_SETUP;
                end
                S_SETUP:
                begin
                    // address and data settle before the strobe
                    pins.addr <= polling_q ? addr_q : seq_q[idx_q].addr;
                    pins.dq_out <= seq_q[idx_q].data;
                    pins.dq_oe <= !(polling_q || seq_q[idx_q].rd);
                    if (cnt_q == '0)
                    begin
                        pins.chip_select_n <= 1'b0;
                        if (polling_q || seq_q[idx_q].rd)
                            pins.output_enable_n <= 1'b0;
                        else
                            pins.write_strobe_n <= 1'b0;
                        cnt_q <= CNT_W'(STROBE_CYC); state_q <= S_STROBE;
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                S_STROBE:
                if (cnt_q == '0)
                begin
                    pins.write_strobe_n <= 1'b1; pins.output_enable_n <= 1'b1;
                    pins.chip_select_n <= 1'b1;
                    if (polling_q || seq_q[idx_q].rd)
                        rdata_q <= dq_s2_q;
                    cnt_q <= CNT_W'(SETUP_CYC); state_q <= S_HOLD;
                end
                else
                    cnt_q <= cnt_q - 1'b1;
                S_HOLD:
                if (cnt_q != '0)
                    cnt_q <= cnt_q - 1'b1;
                else
                begin
                    pins.dq_oe <= 1'b0;
                    if (!polling_q && idx_q + 3'd1 < nsteps_q)
                    begin
                        idx_q <= idx_q + 3'd1; cnt_q <= CNT_W'(SETUP_CYC); state_q <= S_SETUP;
                    end
                    else if (!polling_q && (op_q == OP_PROG || op_q == OP_BYP_PROG ||
                             op_q == OP_SECT_ERASE || op_q == OP_CHIP_ERASE ||
                             op_q == OP_SUSPEND || op_q == OP_RESUME))
                    begin
                        polling_q <= 1'b1; cnt_q <= CNT_W'(SETUP_CYC); state_q <= S_SETUP;
                    end
                    else if (polling_q)
                        state_q <= S_POLL;
                    else
                        state_q <= S_DONE;
                end
                S_POLL:
                begin
                    prev_q <= rdata_q; have_prev_q <= 1'b1;
                    cnt_q <= CNT_W'(SETUP_CYC); state_q <= S_SETUP;
                    if (final_rd_q)
                        state_q <= S_DONE;
                    else if (have_prev_q && rdata_q[TOGGLE_A] == prev_q[TOGGLE_A])
                    begin
                        // toggling stopped: finished, suspended or protected
                        final_rd_q <= 1'b1;
                        if (op_q == OP_SUSPEND)
                            suspended_q <= 1'b1;
                        if (op_q == OP_SECT_ERASE || op_q == OP_CHIP_ERASE)
                            erasing_q <= 1'b0;
                    end
                    else if (have_prev_q && rdata_q[TIMEOUT_F])
                    begin
                        if (recheck_q)
                        begin
                            // still toggling after recheck: failure, send reset
                            fail_q <= 1'b1; polling_q <= 1'b0; idx_q <= 3'd0;
                            erasing_q <= 1'b0;
                        end
                        recheck_q <= 1'b1;
                    end
                    if (have_prev_q && op_q == OP_SECT_ERASE && rdata_q[TOGGLE_A] !=
                        prev_q[TOGGLE_A])
                        erasing_q <= 1'b1;
                    if (op_q == OP_RESUME)
                        suspended_q <= 1'b0;
                end
                S_DONE:
                begin
                    busy_q <= 1'b0; done_q <= 1'b1;
                    if (op_q == OP_BYP_ENTER)
                        bypass_q <= 1'b1;
                    if (op_q == OP_BYP_EXIT || op_q == OP_RESET)
                        bypass_q <= 1'b0;
                    if (op_q == OP_RESET && !fail_q)
                        erasing_q <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule : flash_ctl
`default_nettype wire

// ===== hdl/flash_ctl_pkg.sv
/*
 * package for the flash command controller: register offsets, command codes,
 * pin bundle layout and bus timing counts.
 * assumes a 200 MHz aclk and a flash part on an asynchronous parallel bus.
 */
`default_nettype none
package flash_ctl_pkg;
    // clock rate and bus timing
    localparam int CLK_MHZ = 200;
    localparam int STROBE_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_NS = 20;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_ADDR = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    // command register operation codes
    localparam logic [3:0] OP_READ = 4'h1;
    localparam logic [3:0] OP_PROG = 4'h2;
    localparam logic [3:0] OP_SECT_ERASE = 4'h3;
    localparam logic [3:0] OP_CHIP_ERASE = 4'h4;
    localparam logic [3:0] OP_SUSPEND = 4'h5;
    localparam logic [3:0] OP_RESUME = 4'h6;
    localparam logic [3:0] OP_RESET = 4'h7;
    localparam logic [3:0] OP_AUTOSEL = 4'h8;
    localparam logic [3:0] OP_BYP_ENTER = 4'h9;
    localparam logic [3:0] OP_BYP_PROG = 4'hA;
    localparam logic [3:0] OP_BYP_EXIT = 4'hB;
    localparam logic [3:0] OP_RAW_WRITE = 4'hC;
    // flash command values
    localparam logic [15:0] UNLOCK_A1 = 16'h0555;
    localparam logic [15:0] UNLOCK_A2 = 16'h02AA;
    localparam logic [7:0] UNLOCK_D1 = 8'hAA;
    localparam logic [7:0] UNLOCK_D2 = 8'h55;
    localparam logic [7:0] FC_PROG = 8'hA0;
    localparam logic [7:0] FC_ERASE = 8'h80;
    localparam logic [7:0] FC_CHIP = 8'h10;
    localparam logic [7:0] FC_SECT = 8'h30;
    localparam logic [7:0] FC_SUSP = 8'hB0;
    localparam logic [7:0] FC_RESUME = 8'h30;
    localparam logic [7:0] FC_RESET = 8'hF0;
    localparam logic [7:0] FC_AUTOSEL = 8'h90;
    localparam logic [7:0] FC_BYPASS = 8'h20;
    localparam logic [7:0] FC_BYP_RST2 = 8'h00;
    // status bit positions in read data
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_A = 6;
    localparam int TIMEOUT_F = 5;
    localparam int TIMER_F = 3;
    localparam int TOGGLE_B = 2;
    // one flash bus cycle step: address and data
    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] data;
        logic rd;
    } step_t;
    // pins driven toward the flash
    typedef struct packed {
        logic [20:0] addr;
        logic chip_select_n;
        logic write_strobe_n;
        logic output_enable_n;
        logic [15:0] dq_out;
        logic dq_oe;
    } pins_t;
endpackage : flash_ctl_pkg
`default_nettype wire

// ===== tb/flash_ctl_props.sv
/* checker for flash_ctl: bus handshakes and flash pin sequencing.
 * assumes a bind onto flash_ctl by name and the single clock aclk. */
`default_nettype none
module flash_ctl_props
    import flash_ctl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_awready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire flash_ctl_pkg::pins_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus answers stand until taken
    property p_b_hold; s_bvalid && !s_bready |=> s_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed");
    property p_r_next; s_arvalid && s_arready |=> s_rvalid; endproperty
    a_r_next: assert property (p_r_next) else $error("read answer late");
    property p_aw_block; s_bvalid |-> !s_awready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken during response");
    // flash write cycles: selected, driven, no read overlap
    property p_wr_only; !pins.write_strobe_n |->
        pins.output_enable_n && !pins.chip_select_n && pins.dq_oe; endproperty
    a_wr_only: assert property (p_wr_only) else $error("bad write cycle");
    property p_wr_stable; !pins.write_strobe_n && $past(!pins.write_strobe_n) |->
        $stable(pins.addr) && $stable(pins.dq_out); endproperty
    a_wr_stable: assert property (p_wr_stable) else $error("moved under strobe");
    property p_wr_width; $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*8]; endproperty
    a_wr_width: assert property (p_wr_width) else $error("strobe too short");
    property p_unlock; $fell(pins.write_strobe_n) && pins.dq_out == 16'h00AA |->
        pins.addr == 21'(UNLOCK_A1); endproperty
    a_unlock: assert property (p_unlock) else $error("bad unlock cycle");
    property p_rd_free; !pins.output_enable_n |-> !pins.dq_oe && pins.write_strobe_n; endproperty
    a_rd_free: assert property (p_rd_free) else $error("driven during read");
    // main scenarios reached
    c_write: cover property ($fell(pins.write_strobe_n));
    c_read: cover property ($fell(pins.output_enable_n));
    c_answer: cover property (s_rvalid && s_rready);
endmodule : flash_ctl_props
bind flash_ctl flash_ctl_props i_props (.aclk(aclk), .aresetn(aresetn),
    .s_awready(s_awready), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .pins(pins));
`default_nettype wire

// ===== tb/flash_model.sv
/* behavioural flash on the controller pins: command latch, status while busy.
 * assumes pins change only on aclk edges. */
`default_nettype none
module flash_model
    import flash_ctl_pkg::*;
(
    input wire logic aclk,
    input wire flash_ctl_pkg::pins_t pins,
    input wire logic fail_mode,
    output logic [15:0] dq_in,
    output logic ready_busy_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ws_q = 1'b1;
    logic oe_q = 1'b1;
    logic cs_q = 1'b1;
    logic tog = 1'b0;
    logic [2:0] busy = 3'h0;
    logic [7:0] last_cmd = 8'h00;
    logic [15:0] prog_d = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    logic [15:0] word;
    logic drive;
    // latch low byte at strobe rise, count down busy reads
    always @(posedge aclk)
    begin
        ws_q <= pins.write_strobe_n;
        oe_q <= pins.output_enable_n;
        cs_q <= pins.chip_select_n;
        // strobe and select rise together: use the select of the last cycle
        if (!ws_q && pins.write_strobe_n && !cs_q)
        begin
            last_cmd <= pins.dq_out[7:0];
            if (pins.dq_out[7:0] == FC_RESET)
                busy <= 3'h0;
            if (pins.dq_out[7:0] == FC_SECT || pins.dq_out[7:0] == FC_CHIP)
            begin
                prog_d <= 16'hFFFF;
                busy <= 3'h6;
            end
            if (last_cmd == FC_PROG)
            begin
                prog_d <= pins.dq_out;
                busy <= 3'h6;
            end
        end
        if (!oe_q && pins.output_enable_n && busy != 3'h0)
        begin
            tog <= ~tog;
            if (!fail_mode)
                busy <= busy - 3'h1;
        end
        if (drive)
            last_q <= word;
    end
    // status at any address while busy, array pattern otherwise; released bus inverts
    assign drive = !pins.chip_select_n && !pins.output_enable_n;
    assign word = (busy != 3'h0) ? {8'h00, ~prog_d[7], tog, fail_mode, 2'b01, tog, 2'b00}
        : pins.addr[15:0] ^ 16'h5A3C;
    assign dq_in = drive ? word : ~last_q;
    assign ready_busy_n = (busy == 3'h0);
endmodule : flash_model
`default_nettype wire

// ===== tb/test_flash_ctl.sv
/* self-checking bench for flash_ctl: AXI4-Lite master tasks, queued reads.
 * assumes flash_model on the pins and the bound checker. */
`default_nettype none
module test_flash_ctl
    import flash_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0;
    logic aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, fail_mode;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ready_busy_n;
    logic [1:0] s_bresp, s_rresp;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, last_rd, a, seed;
    logic [15:0] dq_in;
    logic [63:0] ent;
    logic [63:0] exp_q[$];
    pins_t pins;
    int num_errors = 0;
    int total_checks = 0;
    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    flash_ctl i_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .pins(pins), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
    flash_model i_flash (.aclk(aclk), .pins(pins), .fail_mode(fail_mode), .dq_in(dq_in),
        .ready_busy_n(ready_busy_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        s_awaddr <= ad;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        fork
            @(posedge aclk iff s_awready) s_awvalid <= 1'b0;
            @(posedge aclk iff s_wready) s_wvalid <= 1'b0;
        join
        @(posedge aclk iff s_bvalid) s_bready <= 1'b0;
    endtask : axi_wr
    // note the expectation, then read; mask 0 means no comparison of value
    task automatic axi_rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({e, m});
        @(posedge aclk);
        s_araddr <= ad;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        @(posedge aclk iff s_arready) s_arvalid <= 1'b0;
        @(posedge aclk iff s_rvalid) s_rready <= 1'b0;
        @(negedge aclk);
    endtask : axi_rd
    task automatic op(input logic [3:0] code);
        int n;
        n = 0;
        axi_wr(OFS_CMD, {28'h0, code});
        do
        begin
            axi_rd(OFS_STAT, 32'h0, 32'h0);
            n++;
        end while (last_rd[0] !== 1'b0 && n < 400);
        if (n >= 400)
            num_errors++;
    endtask : op
    // compare each read answer with the oldest note
    always @(posedge aclk)
    begin
        if (s_rvalid && s_rready)
        begin
            ent = exp_q.pop_front();
            check(s_rdata & ent[31:0], ent[63:32] & ent[31:0]);
            check({30'h0, s_rresp}, 32'h0);
            last_rd <= s_rdata;
        end
        if (s_bvalid && s_bready)
            check({30'h0, s_bresp}, 32'h0);
    end
    initial
    begin
        #400000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, fail_mode} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        seed = 32'h000152ED;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(OFS_STAT, 32'h0, 32'h000000FF);
        axi_rd(8'h1C, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++)
        begin
            a = rnd();
            axi_wr(OFS_ADDR, a);
            axi_rd(OFS_ADDR, a, 32'h001FFFFF);
            op(OP_READ);
            axi_rd(OFS_RDATA, a ^ 32'h00005A3C, 32'h0000FFFF);
        end
        axi_wr(OFS_DATA, rnd());
        op(OP_PROG);
        axi_rd(OFS_STAT, {21'h0, ~a[2], ~a[3], 9'h102}, 32'h707);
        axi_wr(OFS_CMD, {28'h0, OP_SECT_ERASE});
        axi_wr(OFS_ADDR, 32'h0);
        op(4'h0);
        axi_rd(OFS_ADDR, a, 32'h001FFFFF);
        fail_mode <= 1'b1;
        op(OP_PROG);
        fail_mode <= 1'b0;
        axi_rd(OFS_STAT, 32'h4, 32'h5);
        op(OP_BYP_ENTER);
        axi_rd(OFS_STAT, 32'h20, 32'h20);
        op(OP_BYP_PROG);
        axi_rd(OFS_STAT, 32'h22, 32'h23);
        op(OP_BYP_EXIT);
        axi_rd(OFS_STAT, 32'h0, 32'h20);
        op(OP_SUSPEND);
        axi_rd(OFS_STAT, 32'h0, 32'h80);
        repeat (4) @(posedge aclk);
        end_of_test();
    end
endmodule : test_flash_ctl
`default_nettype wire
